// ===== verilog/elc_map.svh
// Register offsets, reset values and field masks of the external line controller.
`ifndef ELC_MAP_SVH
`define ELC_MAP_SVH

// =====================================================================
// Register offsets (byte addresses).
`define ELC_OFF_IMASK   5'h00
`define ELC_OFF_EMASK   5'h04
`define ELC_OFF_RTEN    5'h08
`define ELC_OFF_FTEN    5'h0c
`define ELC_OFF_SWTRIG  5'h10
`define ELC_OFF_PEND    5'h14

// =====================================================================
// Reset values and implemented line positions.
`define ELC_RST_IMASK   32'h7f840000
`define ELC_RST_EMASK   32'h00000000
`define ELC_RST_EDGE    32'h00000000
`define ELC_RST_ZERO    32'h00000000
`define ELC_LINE_MASK   32'h807bffff

`endif

// ===== verilog/elc_pkg.sv
// Types shared by the external line controller.
`default_nettype none
package elc_pkg;
    typedef logic [31:0] elc_word_t;
    typedef enum logic [2:0] {
        ELC_R_IMASK  = 3'b000,
        ELC_R_EMASK  = 3'b001,
        ELC_R_RTEN   = 3'b010,
        ELC_R_FTEN   = 3'b011,
        ELC_R_SWTRIG = 3'b100,
        ELC_R_PEND   = 3'b101,
        ELC_R_NONE   = 3'b111
    } elc_reg_t;
endpackage
`default_nettype wire

// ===== verilog/elc_edge_detect.sv
// Line synchroniser and edge strobe generator.
`timescale 1ns/1ps
`default_nettype none
module elc_edge_detect #(
    parameter int N = 32
) (
    input  wire logic         clk,      // Bus clock.
    input  wire logic         reset,    // Asynchronous reset, active high.
    input  wire logic [N-1:0] line_in,  // Raw line levels.
    output logic      [N-1:0] rise,     // One-cycle rising strobe per line.
    output logic      [N-1:0] fall      // One-cycle falling strobe per line.
);
    logic [N-1:0] meta_q;
    logic [N-1:0] sync_q;
    logic [N-1:0] prev_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= line_in;
            sync_q <= meta_q;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prev_q <= '0;
        end else begin
            prev_q <= sync_q;
        end
    end

    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;

    property p_rise_once;
        @(posedge clk) disable iff (reset)
        (|rise) |=> ((rise & $past(rise)) == '0);
    endproperty
    a_rise_once: assert property (p_rise_once) else $error("rising strobe longer than one cycle");

    property p_fall_cause;
        @(posedge clk) disable iff (reset)
        (|fall) |-> ((fall & ~($past(sync_q) & ~sync_q)) == '0);
    endproperty
    a_fall_cause: assert property (p_fall_cause) else $error("falling strobe without transition");
endmodule // elc_edge_detect
`default_nettype wire

// ===== verilog/elc_ctrl.sv
// External line interrupt and event controller with Avalon-MM register slave.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "elc_map.svh"
module elc_ctrl
    import elc_pkg::*;
#(
    parameter int N = 32
) (
    input  wire logic         clk,          // Bus clock, 20 MHz.
    input  wire logic         reset,        // Asynchronous reset, active high.
    input  wire logic [4:0]   address,      // Avalon byte address.
    input  wire logic         read,         // Avalon read request.
    input  wire logic         write,        // Avalon write request.
    input  wire logic [31:0]  writedata,    // Avalon write data.
    input  wire logic [3:0]   byteenable,   // Avalon byte lanes.
    output logic      [31:0]  readdata,     // Avalon read data.
    output logic              waitrequest,  // Avalon stall.
    output logic      [1:0]   response,     // Avalon response, 2'b10 on unmapped.
    input  wire logic [N-1:0] line_in,      // External and peripheral lines.
    output logic      [N-1:0] event_out,    // One-cycle event pulses.
    output logic              irq           // Level interrupt request.
);
    // =====================================================================
    // Helper functions.
    function automatic elc_reg_t reg_decode(input logic [4:0] a);
        case (a)
            `ELC_OFF_IMASK:  reg_decode = ELC_R_IMASK;
            `ELC_OFF_EMASK:  reg_decode = ELC_R_EMASK;
            `ELC_OFF_RTEN:   reg_decode = ELC_R_RTEN;
            `ELC_OFF_FTEN:   reg_decode = ELC_R_FTEN;
            `ELC_OFF_SWTRIG: reg_decode = ELC_R_SWTRIG;
            `ELC_OFF_PEND:   reg_decode = ELC_R_PEND;
            default:         reg_decode = ELC_R_NONE;
        endcase
    endfunction

    function automatic elc_word_t lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic elc_word_t lane_merge(input elc_word_t old_v,
                                             input elc_word_t new_v,
                                             input logic [3:0] be);
        lane_merge = (old_v & ~lane_mask(be)) | (new_v & lane_mask(be));
    endfunction

    // =====================================================================
    // Bus handshake: every access takes two cycles.
    logic      ack_q;
    elc_reg_t  sel;
    logic      req;
    logic      fire_wr;
    elc_word_t wbits;
    elc_word_t readdata_q;
    logic [1:0] response_q;

    assign sel         = reg_decode(address);
    assign req         = read | write;
    assign waitrequest = req & ~ack_q;
    assign fire_wr     = write & ack_q;
    assign wbits       = writedata & lane_mask(byteenable);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    logic wr_imask;
    logic wr_emask;
    logic wr_rten;
    logic wr_ften;
    logic wr_swt;
    logic wr_pend;

    assign wr_imask = fire_wr && (sel == ELC_R_IMASK);
    assign wr_emask = fire_wr && (sel == ELC_R_EMASK);
    assign wr_rten  = fire_wr && (sel == ELC_R_RTEN);
    assign wr_ften  = fire_wr && (sel == ELC_R_FTEN);
    assign wr_swt   = fire_wr && (sel == ELC_R_SWTRIG);
    assign wr_pend  = fire_wr && (sel == ELC_R_PEND);

    // =====================================================================
    // Configuration registers.
    elc_word_t imask_q;
    elc_word_t emask_q;
    elc_word_t rten_q;
    elc_word_t ften_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            imask_q <= `ELC_RST_IMASK;
        end else if (wr_imask) begin
            imask_q <= lane_merge(imask_q, writedata, byteenable);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            emask_q <= `ELC_RST_EMASK;
        end else if (wr_emask) begin
            emask_q <= lane_merge(emask_q, writedata, byteenable);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rten_q <= `ELC_RST_EDGE;
        end else if (wr_rten) begin
            rten_q <= lane_merge(rten_q, writedata, byteenable) & `ELC_LINE_MASK;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ften_q <= `ELC_RST_EDGE;
        end else if (wr_ften) begin
            ften_q <= lane_merge(ften_q, writedata, byteenable) & `ELC_LINE_MASK;
        end
    end

    // =====================================================================
    // Edge detection and trigger qualification.
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    logic         suppress;
    elc_word_t    swt_q;
    elc_word_t    trig_v;
    elc_word_t    sw_new;
    elc_word_t    set_v;

    elc_edge_detect #(
        .N       (N)
    ) u_edge (
        .clk     (clk),
        .reset   (reset),
        .line_in (line_in),
        .rise    (rise),
        .fall    (fall)
    );

    // An edge landing in the same cycle as an edge-enable write is dropped.
    assign suppress = wr_rten | wr_ften;
    assign trig_v   = suppress ? '0 : ((rise & rten_q) | (fall & ften_q));
    assign sw_new   = wr_swt ? (wbits & ~swt_q & `ELC_LINE_MASK) : '0;
    assign set_v    = (trig_v & imask_q) | sw_new;

    // =====================================================================
    // Software trigger and pending flags.
    elc_word_t pend_q;
    elc_word_t pend_clr;

    assign pend_clr = wr_pend ? wbits : '0;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            swt_q <= `ELC_RST_ZERO;
        end else begin
            swt_q <= (swt_q & ~pend_clr) | sw_new;
        end
    end

    // A new set in the clearing cycle survives the clear.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pend_q <= `ELC_RST_ZERO;
        end else begin
            pend_q <= ((pend_q & ~pend_clr) | set_v) & `ELC_LINE_MASK;
        end
    end

    // =====================================================================
    // Event pulses and interrupt output.
    logic [N-1:0] event_q;
    logic         irq_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            event_q <= '0;
        end else begin
            event_q <= (trig_v | sw_new) & emask_q;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(((pend_q & ~pend_clr) | set_v) & imask_q);
        end
    end

    assign event_out = event_q;
    assign irq       = irq_q;

    // =====================================================================
    // Read data and response, captured when the request is first seen.
    elc_word_t rd_mux;

    always_comb begin
        case (sel)
            ELC_R_IMASK:  rd_mux = imask_q;
            ELC_R_EMASK:  rd_mux = emask_q;
            ELC_R_RTEN:   rd_mux = rten_q;
            ELC_R_FTEN:   rd_mux = ften_q;
            ELC_R_SWTRIG: rd_mux = swt_q;
            ELC_R_PEND:   rd_mux = pend_q;
            default:      rd_mux = '0;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            readdata_q <= '0;
        end else if (read & ~ack_q) begin
            readdata_q <= rd_mux;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            response_q <= 2'h0;
        end else if (req & ~ack_q) begin
            response_q <= (sel == ELC_R_NONE) ? 2'h2 : 2'h0;
        end
    end

    assign readdata = readdata_q;
    assign response = response_q;

    // =====================================================================
    // Assertions.
    sequence s_req_seen;
        req && waitrequest;
    endsequence

    sequence s_ack;
        req && !waitrequest;
    endsequence

    property p_two_cycle;
        @(posedge clk) disable iff (reset)
        s_req_seen |=> s_ack;
    endproperty
    a_two_cycle: assert property (p_two_cycle) else $error("access not answered in one cycle");

    property p_read_imask;
        @(posedge clk) disable iff (reset)
        (read && !waitrequest && sel == ELC_R_IMASK) |-> (readdata == $past(imask_q));
    endproperty
    a_read_imask: assert property (p_read_imask) else $error("interrupt mask read wrong");

    property p_pend_needs_open;
        @(posedge clk) disable iff (reset)
        1'b1 |=> ((pend_q & ~$past(pend_q) & ~$past(imask_q) & ~$past(sw_new)) == '0);
    endproperty
    a_pend_needs_open: assert property (p_pend_needs_open) else $error("masked line set pending");

    property p_event_masked;
        @(posedge clk) disable iff (reset)
        1'b1 |=> ((event_q & ~$past(emask_q)) == '0);
    endproperty
    a_event_masked: assert property (p_event_masked) else $error("masked line gave event");

    property p_reserved_zero;
        @(posedge clk) disable iff (reset)
        (((rten_q | ften_q) & ~`ELC_LINE_MASK) == '0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved enable bit set");

    property p_fall_sets;
        @(posedge clk) disable iff (reset)
        (!suppress && |(fall & ften_q & imask_q))
            |=> ((pend_q & $past(fall & ften_q & imask_q)) == $past(fall & ften_q & imask_q));
    endproperty
    a_fall_sets: assert property (p_fall_sets) else $error("falling edge lost");

    property p_write_blocks;
        @(posedge clk) disable iff (reset)
        suppress |=> ((pend_q & ~$past(pend_q)) == '0);
    endproperty
    a_write_blocks: assert property (p_write_blocks) else $error("edge taken during enable write");

    property p_w1c;
        @(posedge clk) disable iff (reset)
        wr_pend |=> ((pend_q & $past(wbits & ~set_v)) == '0) && ((swt_q & $past(wbits)) == '0);
    endproperty
    a_w1c: assert property (p_w1c) else $error("pending not cleared by write one");

    property p_event_no_pend;
        @(posedge clk) disable iff (reset)
        1'b1 |=> ((pend_q & $past(trig_v & emask_q & ~imask_q & ~pend_q & ~sw_new)) == '0);
    endproperty
    a_event_no_pend: assert property (p_event_no_pend) else $error("event set pending");

    property p_sw_trigger;
        @(posedge clk) disable iff (reset)
        (|sw_new) |=> ((pend_q & $past(sw_new)) == $past(sw_new))
                      && ((swt_q & $past(sw_new)) == $past(sw_new));
    endproperty
    a_sw_trigger: assert property (p_sw_trigger) else $error("software trigger lost");

    property p_irq_level;
        @(posedge clk) disable iff (reset)
        1'b1 |=> (irq == |(pend_q & $past(imask_q)));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");
endmodule // elc_ctrl
`default_nettype wire

// ===== testbench/elc_line_src.sv
// Model of the pins and peripheral event lines that feed the controller.
`timescale 1ns/1ps
`default_nettype none
module elc_line_src #(
    parameter int N = 32
) (
    input  wire logic         clk,      // Bus clock.
    input  wire logic         reset,    // Asynchronous reset, active high.
    input  wire logic [N-1:0] level,    // Level that the source is asked to show.
    output logic      [N-1:0] line_in   // Line levels seen by the controller.
);
    // ==========
    // Line drive
    // Lines change only on a clock edge, so each level is clean and glitch free.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            line_in <= '0;
        end else begin
            line_in <= level;
        end
    end
endmodule // elc_line_src
`default_nettype wire

// ===== testbench/elc_ctrl_tb.sv
// Self-checking testbench of the external line controller.
`timescale 1ns/1ps
`default_nettype none
`include "elc_map.svh"
module elc_ctrl_tb;
    import elc_pkg::*;
    logic        clk = 0;
    logic        reset = 1;
    logic [4:0]  address = '0;
    logic        read = 0;
    logic        write = 0;
    logic [31:0] writedata = '0;
    logic [3:0]  byteenable = 4'hf;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [1:0]  response;
    logic [31:0] level = '0;
    logic [31:0] line_in;
    logic [31:0] event_out;
    logic        irq;
    logic [31:0] ev_seen = '0;
    logic        ev_clr = 0;
    int          fail_count = 0;
    int          comparisons = 0;

    elc_ctrl #(.N(32)) dut_u (.clk(clk), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .response(response), .line_in(line_in),
        .event_out(event_out), .irq(irq));
    elc_line_src #(.N(32)) src_u (.clk(clk), .reset(reset), .level(level), .line_in(line_in));

    initial begin
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        ev_seen <= ev_clr ? 32'h00000000 : (ev_seen | event_out);
    end

    // ==========
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) fail_count++;
        q = readdata;
        r = response;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic [1:0]  r;
        bus(1'b1, a, d, q, r);
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] q);
        logic [1:0] r;
        bus(1'b0, a, 32'h00000000, q, r);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    function automatic logic [31:0] edges(input logic [31:0] o, c, re, fe);
        return ((c & ~o & re) | (o & ~c & fe)) & `ELC_LINE_MASK;
    endfunction

    // ==========
    // Watchdog
    initial begin
        #3000000;
        fail_count++;
        end_of_test();
    end

    // ==========
    // Tests
    initial begin
        logic [31:0] q, im, em, re, fe, old, cur, e;
        logic [1:0]  r;
        int          drops;
        void'($urandom(32'h882ef606));
        wait_clk(5);
        reset <= 1'b0;
        rd(`ELC_OFF_IMASK, q); check(q, 32'h7f840000);
        rd(`ELC_OFF_EMASK, q); check(q, 32'h00000000);
        rd(`ELC_OFF_RTEN, q); check(q, 32'h00000000);
        rd(`ELC_OFF_FTEN, q); check(q, 32'h00000000);
        bus(1'b0, 5'h18, 32'h0, q, r); check({30'h0, r}, 32'h2);
        check(q, 32'h00000000);
        wr(`ELC_OFF_RTEN, 32'hffffffff);
        wr(`ELC_OFF_FTEN, 32'hffffffff);
        rd(`ELC_OFF_RTEN, q); check(q, 32'h807bffff);
        rd(`ELC_OFF_FTEN, q); check(q, 32'h807bffff);
        $display("test reset_and_map done");
        cur = '0;
        for (int i = 0; i < 24; i++) begin
            im = (i < 2) ? 32'hffffffff : $urandom;
            em = (i < 2) ? 32'hffffffff : $urandom;
            re = (i < 2) ? 32'hffffffff : $urandom;
            fe = (i < 2) ? 32'hffffffff : $urandom;
            wr(`ELC_OFF_IMASK, im);
            wr(`ELC_OFF_EMASK, em);
            wr(`ELC_OFF_RTEN, re);
            wr(`ELC_OFF_FTEN, fe);
            wr(`ELC_OFF_PEND, 32'hffffffff);
            ev_clr <= 1'b1;
            wait_clk(1);
            ev_clr <= 1'b0;
            old = cur;
            cur = (i == 1) ? ~old : $urandom;
            level <= cur;
            wait_clk(10);
            e = edges(old, cur, re, fe);
            rd(`ELC_OFF_PEND, q); check(q, e & im);
            check(ev_seen, e & em);
            check({31'h0, irq}, {31'h0, |(e & im)});
        end
        $display("test random_edges done");
        wr(`ELC_OFF_IMASK, 32'h00000001);
        wr(`ELC_OFF_EMASK, 32'h00000000);
        wr(`ELC_OFF_FTEN, 32'h00000000);
        drops = 0;
        for (int k = 0; k < 8; k++) begin
            level <= 32'h0;
            wait_clk(8);
            wr(`ELC_OFF_RTEN, 32'h00000001);
            wr(`ELC_OFF_PEND, 32'hffffffff);
            level <= 32'h1;
            wait_clk(k);
            wr(`ELC_OFF_RTEN, 32'h00000001);
            wait_clk(8);
            rd(`ELC_OFF_PEND, q);
            if (q[0] !== 1'b1) drops++;
        end
        check(32'(drops), 32'h1);
        $display("test write_during_edge done");
        level <= 32'h0;
        wr(`ELC_OFF_RTEN, 32'h0);
        wr(`ELC_OFF_PEND, 32'hffffffff);
        wr(`ELC_OFF_IMASK, 32'h0);
        wr(`ELC_OFF_EMASK, 32'h00000008);
        ev_clr <= 1'b1;
        wait_clk(1);
        ev_clr <= 1'b0;
        wr(`ELC_OFF_SWTRIG, 32'h00000008);
        wait_clk(3);
        rd(`ELC_OFF_PEND, q); check(q, 32'h00000008);
        check(ev_seen, 32'h00000008);
        check({31'h0, irq}, 32'h0);
        wr(`ELC_OFF_IMASK, 32'h00000008);
        wait_clk(2);
        check({31'h0, irq}, 32'h1);
        wr(`ELC_OFF_PEND, 32'h00000008);
        wait_clk(2);
        rd(`ELC_OFF_PEND, q); check(q, 32'h0);
        rd(`ELC_OFF_SWTRIG, q); check(q, 32'h0);
        check({31'h0, irq}, 32'h0);
        byteenable <= 4'h2;
        wr(`ELC_OFF_EMASK, 32'hffffffff);
        byteenable <= 4'hf;
        rd(`ELC_OFF_EMASK, q); check(q, 32'h0000ff08);
        $display("test software_trigger done");
        end_of_test();
    end
endmodule // elc_ctrl_tb
`default_nettype wire
